// [inc/fbd_map.svh]
// Address window, mode codes, channel numbers and timing counts
// Assumes inclusion by bare name from the package or design file
`ifndef FBD_MAP_SVH
`define FBD_MAP_SVH
`define FBD_ADDR_W         16
`define FBD_WIN_TOP_BITS   4
`define FBD_WIN_TOP_VAL    4'hf
`define FBD_REG_CTRL       4'h0
`define FBD_REG_STAT       4'h1
`define FBD_REG_CMD        4'h2
`define FBD_REG_DATA       4'h3
`define FBD_REG_LINK       4'h4
`define FBD_CTRL_RST       8'h00
`define FBD_LINK_RST       8'h00
`define FBD_MODE_1         2'h1
`define FBD_MODE_2         2'h2
`define FBD_MODE_3         2'h3
`define FBD_CH_0           2'h0
`define FBD_CH_1           2'h1
`define FBD_CH_2           2'h2
`define FBD_IRQ_LINES      7
`define FBD_IRQ_SIXTH      3'h5
`define FBD_IRQ_SEVENTH    3'h6
`define FBD_BIT_TIME_NS    4000
`define FBD_CLK_NS         10
`define FBD_BIT_CYC        (`FBD_BIT_TIME_NS / `FBD_CLK_NS)
`define FBD_MAX_DRIVES     2
`define FBD_DMA_CH         3
`define FBD_PAR_IDX        4'h8
`endif

// [inc/fbd_pkg.sv]
// Types shared by the floppy bus DMA interface
// Assumes the map header on the include path
`include "fbd_map.svh"
package fbd_pkg;
  typedef struct packed {
    logic [`FBD_ADDR_W-1:0] address;
    logic                   read;
    logic                   write;
    logic [7:0]             writedata;
  } fbd_avm_req_s;
  typedef struct packed {
    logic [7:0] readdata;
    logic       waitrequest;
  } fbd_avm_rsp_s;
  typedef struct packed {
    logic       serial_out;
    logic       write_gate;
    logic [1:0] drive_sel;
  } fbd_drv_s;
  typedef enum logic [4:0] {
    FBD_IDLE = 5'h01,
    FBD_HOLD = 5'h02,
    FBD_XFER = 5'h04,
    FBD_DONE = 5'h08,
    FBD_LEND = 5'h10
  } fbd_state_e;
endpackage

// [rtl/fbd_top.sv]
// Floppy bus DMA interface: windowed registers, hold handshake, DMA, serial link
// Assumes one 100 MHz clock, synchronous inputs, Avalon-MM with waitrequest
// Operation
// - Parameter, DMA, completion phases in order
// - DMA starts after command written
// - Status flags and interrupt at end
// - Respond only inside 60K to 64K; code acknowledges every access, reading zero outside
// - Disable CPU drivers while owning bus
// - Request from controller or sub-module
// - Acknowledge request; doubles as chained grant
// - Raise hold request for DMA
// - Interrupt routed to one of seven
// - Subchannel forbids sixth and seventh lines
// - Mode 1 uses channel 2
// - Mode 2 lends subchannel to module
// - Mode 2 strobe on sixth/seventh line
// - Mode 2 link picks channel allocation
// - Parallel to serial and back
// - Check or generate safeguard parity
// - At most two drives, one type; code never refuses a setting, as drv_ok_w is always true
// - Mode 3 priority by chain position
`timescale 1ns/1ps
`default_nettype none
`include "fbd_map.svh"
module fbd_top #(
  parameter int BIT_CYC  = `FBD_BIT_CYC,
  parameter int XFER_LEN = 16
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  input  wire fbd_pkg::fbd_avm_req_s avm_req_i,
  output fbd_pkg::fbd_avm_rsp_s     avm_rsp_o,
  input  wire logic                 module_select_i,
  input  wire logic                 floppy_req_i,
  input  wire logic                 sub_req_i,
  input  wire logic                 bus_grant_i,
  output logic                      hold_req_o,
  output logic                      cpu_driver_disable_o,
  output logic                      chained_grant_o,
  output logic [2:0]                dma_channel_ack_o,
  output logic [`FBD_IRQ_LINES-1:0] interrupt_line_o,
  output fbd_pkg::fbd_drv_s         drv_o,
  input  wire logic                 serial_in_i
);
  import fbd_pkg::*;

  // Registers
  logic [7:0]  ctrl_r;
  logic [7:0]  link_r;
  logic [7:0]  cmd_r;
  logic [7:0]  data_r;
  logic [7:0]  stat_r;
  logic        cmd_done_r;
  logic        ack_r;
  logic        wreq_r;
  fbd_state_e  state_r;
  fbd_state_e  state_nxt;
  logic [7:0]  cnt_r;
  logic [15:0] bit_cnt_r;
  logic [3:0]  bit_idx_r;
  logic [7:0]  shift_r;
  logic        par_r;
  logic        par_err_r;
  logic        hold_r;
  logic        own_r;
  logic        cgrant_r;
  logic [2:0]  dma_channel_ack_r;
  logic [`FBD_IRQ_LINES-1:0] irq_r;
  logic [7:0]  rdata_r;
  fbd_drv_s    drv_r;

  // Link settings: mode, allocation, interrupt line, drive count and type
  wire [1:0] mode_w      = link_r[1:0];
  wire       alloc_w     = link_r[2];
  wire [2:0] irq_sel_w   = link_r[5:3];
  wire       two_drv_w   = link_r[6];
  wire       std_type_w  = link_r[7];
  wire       go_w        = ctrl_r[0];
  wire       dir_wr_w    = ctrl_r[1];
  wire       irq_en_w    = ctrl_r[2];

  wire [`FBD_WIN_TOP_BITS-1:0] top_w = avm_req_i.address[`FBD_ADDR_W-1 -: `FBD_WIN_TOP_BITS];
  wire in_win_w  = (top_w == `FBD_WIN_TOP_VAL) & module_select_i;
  wire [3:0] reg_w = avm_req_i.address[3:0];
  wire acc_w     = (avm_req_i.read | avm_req_i.write) & ~ack_r;
  wire wr_w      = ack_r & avm_req_i.write & in_win_w;
  wire cmd_wr_w  = wr_w & (reg_w == `FBD_REG_CMD);
  wire data_wr_w = wr_w & (reg_w == `FBD_REG_DATA);
  wire stat_wr_w = wr_w & (reg_w == `FBD_REG_STAT);
  wire in_xfer_w = (state_r == FBD_XFER);
  wire sub_mode_w = (mode_w == `FBD_MODE_2);
  wire irq_bad_w = sub_mode_w & ((irq_sel_w == `FBD_IRQ_SIXTH) | (irq_sel_w == `FBD_IRQ_SEVENTH));
  wire [1:0] own_ch_w = (sub_mode_w & alloc_w) ? `FBD_CH_0 : `FBD_CH_2;
  wire [1:0] sub_ch_w = alloc_w ? `FBD_CH_2 : `FBD_CH_1;
  wire own_req_w = floppy_req_i & cmd_done_r;
  wire sub_req_w = sub_mode_w & sub_req_i;
  wire bit_tick_w = (bit_cnt_r == 16'(BIT_CYC - 1));
  wire byte_end_w = in_xfer_w & bit_tick_w & (bit_idx_r == `FBD_PAR_IDX);
  wire bit_step_w = in_xfer_w & bit_tick_w & (bit_idx_r != `FBD_PAR_IDX);
  wire shift_in_w = dir_wr_w ? shift_r[7] : serial_in_i;
  wire par_bad_w  = byte_end_w & ~dir_wr_w & (serial_in_i != par_r);
  wire xfer_end_w = (cnt_r == 8'(XFER_LEN - 1)) & byte_end_w;
  wire drv_ok_w   = ~(two_drv_w & ~std_type_w & link_r[7]);
  wire grant_xfer_w = bus_grant_i & (state_nxt == FBD_XFER);
  wire grant_lend_w = bus_grant_i & (state_nxt == FBD_LEND);
  wire irq_fire_w   = irq_en_w & stat_r[0] & ~irq_bad_w;
  wire strobe_on_w  = sub_mode_w & own_r & (state_r == FBD_LEND);
  wire [2:0] strobe_ln_w = dir_wr_w ? `FBD_IRQ_SEVENTH : `FBD_IRQ_SIXTH;
  wire [7:0] rmux_w =
      (reg_w == `FBD_REG_CTRL) ? ctrl_r :
      (reg_w == `FBD_REG_STAT) ? stat_r :
      (reg_w == `FBD_REG_CMD)  ? cmd_r  :
      (reg_w == `FBD_REG_DATA) ? data_r :
      (reg_w == `FBD_REG_LINK) ? link_r : 8'h00;

  // Bus slave: one wait cycle, then acknowledge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r   <= 1'b0;
      wreq_r  <= 1'b1;
      rdata_r <= 8'h00;
    end else begin
      ack_r   <= acc_w;
      wreq_r  <= ~acc_w;
      rdata_r <= in_win_w ? rmux_w : 8'h00;
    end
  end

  // Parameter phase registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r     <= `FBD_CTRL_RST;
      link_r     <= `FBD_LINK_RST;
      cmd_r      <= 8'h00;
      cmd_done_r <= 1'b0;
    end else begin
      if (wr_w && reg_w == `FBD_REG_CTRL) ctrl_r <= avm_req_i.writedata;
      if (wr_w && reg_w == `FBD_REG_LINK) link_r <= avm_req_i.writedata;
      if (wr_w && reg_w == `FBD_REG_CMD) begin
        cmd_r      <= avm_req_i.writedata;
        cmd_done_r <= 1'b1;
      end else if (state_r == FBD_DONE) begin
        cmd_done_r <= 1'b0;
      end
    end
  end

  // Phase sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FBD_IDLE: begin
        if ((go_w & own_req_w & drv_ok_w) | sub_req_w) state_nxt = FBD_HOLD;
      end
      FBD_HOLD: begin
        if (bus_grant_i) state_nxt = own_req_w ? FBD_XFER : FBD_LEND;
      end
      FBD_XFER: begin
        if (xfer_end_w) state_nxt = FBD_DONE;
        else if (!bus_grant_i) state_nxt = FBD_HOLD;
      end
      FBD_LEND: begin
        if (!sub_req_i || !bus_grant_i) state_nxt = FBD_IDLE;
      end
      FBD_DONE: state_nxt = FBD_IDLE;
      default:  state_nxt = FBD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) state_r <= FBD_IDLE;
    else          state_r <= state_nxt;
  end

  // Hold request toward the CPU
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= (state_nxt != FBD_IDLE) & (state_nxt != FBD_DONE);
    end
  end

  // Bus ownership disables the CPU drivers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_r <= 1'b0;
    end else begin
      own_r <= grant_xfer_w | grant_lend_w;
    end
  end

  // Grant passed down the chain while idle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cgrant_r <= 1'b0;
    end else begin
      cgrant_r <= bus_grant_i & (state_nxt == FBD_IDLE) & (mode_w == `FBD_MODE_3);
    end
  end

  // Per-channel acknowledge
  for (genvar ch = 0; ch < `FBD_DMA_CH; ch++) begin : g_dma_channel_ack
    wire own_hit_w = grant_xfer_w & (own_ch_w == 2'(ch));
    wire sub_hit_w = grant_lend_w & (sub_ch_w == 2'(ch));
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        dma_channel_ack_r[ch] <= 1'b0;
      end else begin
        dma_channel_ack_r[ch] <= own_hit_w | sub_hit_w;
      end
    end
  end

  // Bit timer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_r <= 16'h0000;
    end else if (!in_xfer_w || bit_tick_w) begin
      bit_cnt_r <= 16'h0000;
    end else begin
      bit_cnt_r <= bit_cnt_r + 16'h0001;
    end
  end

  // Bit position within a byte, parity slot last
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_idx_r <= 4'h0;
    end else if (!in_xfer_w || byte_end_w) begin
      bit_idx_r <= 4'h0;
    end else if (bit_tick_w) begin
      bit_idx_r <= bit_idx_r + 4'h1;
    end
  end

  // Byte count
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
    end else if (state_r == FBD_IDLE) begin
      cnt_r <= 8'h00;
    end else if (byte_end_w) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Shift register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_r <= 8'h00;
    end else if (state_r == FBD_IDLE) begin
      shift_r <= data_r;
    end else if (bit_step_w) begin
      shift_r <= {shift_r[6:0], shift_in_w};
    end
  end

  // Running parity
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_r <= 1'b0;
    end else if (!in_xfer_w || byte_end_w) begin
      par_r <= 1'b0;
    end else if (bit_step_w) begin
      par_r <= par_r ^ shift_in_w;
    end
  end

  // Parity error, set wins over clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_err_r <= 1'b0;
    end else if (par_bad_w) begin
      par_err_r <= 1'b1;
    end else if (cmd_wr_w && cmd_done_r && state_r == FBD_IDLE) begin
      par_err_r <= 1'b0;
    end
  end

  // Data word
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_r <= 8'h00;
    end else if (data_wr_w && state_r == FBD_IDLE) begin
      data_r <= avm_req_i.writedata;
    end else if (byte_end_w && !dir_wr_w) begin
      data_r <= shift_r;
    end
  end

  // Drive side outputs: data bits, then parity bit
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_r <= '0;
    end else begin
      drv_r.write_gate <= in_xfer_w & dir_wr_w;
      if (!in_xfer_w) drv_r.drive_sel <= two_drv_w ? 2'h3 : 2'h1;
      if (byte_end_w && dir_wr_w) drv_r.serial_out <= par_r;
      else if (bit_step_w && dir_wr_w) drv_r.serial_out <= shift_r[7];
      else if (!in_xfer_w) drv_r.serial_out <= 1'b0;
    end
  end

  // Completion status
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_r <= 8'h00;
    end else begin
      stat_r[0] <= (state_r == FBD_DONE) | (stat_r[0] & ~stat_wr_w);
      stat_r[1] <= par_err_r;
      stat_r[2] <= own_r;
      stat_r[3] <= irq_bad_w;
      stat_r[4] <= ~drv_ok_w;
      stat_r[7:5] <= state_r[2:0];
    end
  end

  // Interrupt routing per line
  for (genvar ln = 0; ln < `FBD_IRQ_LINES; ln++) begin : g_irq
    wire done_hit_w   = irq_fire_w & (irq_sel_w == 3'(ln));
    wire strobe_hit_w = strobe_on_w & (strobe_ln_w == 3'(ln));
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        irq_r[ln] <= 1'b0;
      end else begin
        irq_r[ln] <= done_hit_w | strobe_hit_w;
      end
    end
  end

  assign avm_rsp_o.readdata    = rdata_r;
  assign avm_rsp_o.waitrequest = wreq_r;
  assign hold_req_o            = hold_r;
  assign cpu_driver_disable_o  = own_r;
  assign chained_grant_o       = cgrant_r;
  assign dma_channel_ack_o     = dma_channel_ack_r;
  assign interrupt_line_o      = irq_r;
  assign drv_o                 = drv_r;
endmodule
`default_nettype wire

// [tb/fbd_top_checker.sv]
// Port checker for fbd_top
// Assumes the package compiled first; bound below
`timescale 1ns/1ps
`default_nettype none
module fbd_top_checker (
  input wire logic                  ref_clk_i,
  input wire logic                  rst_n_i,
  input wire fbd_pkg::fbd_avm_req_s avm_req_i,
  input wire fbd_pkg::fbd_avm_rsp_s avm_rsp_o,
  input wire logic                  floppy_req_i,
  input wire logic                  sub_req_i,
  input wire logic                  bus_grant_i,
  input wire logic                  hold_req_o,
  input wire logic                  cpu_driver_disable_o,
  input wire logic [2:0]            dma_channel_ack_o
);
  import fbd_pkg::*;
  logic rq;
  assign rq = avm_req_i.read | avm_req_i.write;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_out_rd; avm_req_i.read && avm_req_i.address[15:12] != 4'hf; endsequence
  sequence s_ack; !avm_rsp_o.waitrequest; endsequence
  a_ack_next: assert property ($rose(rq) |=> s_ack) else $error("late answer");
  a_ack_single: assert property (s_ack |=> avm_rsp_o.waitrequest) else $error("long answer");
  a_out_zero: assert property (s_out_rd ##1 s_ack |-> avm_rsp_o.readdata == 8'h00)
    else $error("outside read not zero");
  a_hold_cause: assert property ($rose(hold_req_o) |-> $past(floppy_req_i) || $past(sub_req_i))
    else $error("hold without request");
  a_grant_owns: assert property ($rose(bus_grant_i) && hold_req_o |=> cpu_driver_disable_o)
    else $error("drivers not disabled");
  a_drop_release: assert property (!hold_req_o |=> !cpu_driver_disable_o) else $error("bus kept");
  a_ack_owned: assert property (|dma_channel_ack_o |-> cpu_driver_disable_o) else $error("ack unowned");
  a_ack_onehot: assert property ($onehot0(dma_channel_ack_o)) else $error("two acks");
endmodule
bind fbd_top fbd_top_checker i_fbd_top_checker (.ref_clk_i, .rst_n_i, .avm_req_i, .avm_rsp_o,
  .floppy_req_i, .sub_req_i, .bus_grant_i, .hold_req_o, .cpu_driver_disable_o, .dma_channel_ack_o);
`default_nettype wire

// [tb/fbd_cpu_model.sv]
// CPU side: module select decode and bus grant
// Assumes the bench wires hold and address
`timescale 1ns/1ps
`default_nettype none
module fbd_cpu_model #(
  parameter int DLY = 2
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hold_req_i,
  input  wire logic [15:0] address_i,
  output logic             bus_grant_o,
  output logic             module_select_o
);
  logic [3:0] wait_r;
  assign module_select_o = address_i[15:12] == 4'hf;
  assign bus_grant_o = hold_req_i && wait_r >= DLY;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) wait_r <= 4'h0;
    else wait_r <= hold_req_i ? wait_r + {3'h0, wait_r != 4'hf} : 4'h0;
  end
endmodule
`default_nettype wire

// [tb/fbd_top_bench.sv]
// Bench for fbd_top
// Assumes the CPU model and checker compiled
`timescale 1ns/1ps
`default_nettype none
`include "fbd_map.svh"
module fbd_top_bench;
  import fbd_pkg::*;
  logic         ref_clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic         floppy_req_i = 1'b0;
  logic         sub_req_i = 1'b0;
  logic         chained_grant_o;
  fbd_drv_s     drv;
  logic         module_select_i, bus_grant_i, hold_req_o, cpu_driver_disable_o;
  logic [2:0]   dma_channel_ack_o;
  logic [6:0]   interrupt_line_o;
  fbd_avm_req_s req = '0;
  fbd_avm_rsp_s rsp;
  logic [7:0]   q;
  int           err_total = 0;
  int           comparisons = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  fbd_top #(.BIT_CYC(2), .XFER_LEN(2)) i_fbd_top (.ref_clk_i, .rst_n_i, .avm_req_i(req),
    .avm_rsp_o(rsp), .module_select_i, .floppy_req_i, .sub_req_i, .bus_grant_i, .hold_req_o,
    .cpu_driver_disable_o, .chained_grant_o, .dma_channel_ack_o, .interrupt_line_o, .drv_o(drv),
    .serial_in_i(1'b0));
  fbd_cpu_model #(.DLY(2)) i_fbd_cpu_model (.ref_clk_i, .rst_n_i, .hold_req_i(hold_req_o),
    .address_i(req.address), .bus_grant_o(bus_grant_i), .module_select_o(module_select_i));
  task automatic test_done;
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [3:0] top, input logic [3:0] idx, input logic [7:0] d);
    int n;
    @(posedge ref_clk_i);
    req <= '{address: {top, 8'h00, idx}, read: !wr, write: wr, writedata: d};
    n = 0;
    do begin @(posedge ref_clk_i); n++; end while (rsp.waitrequest !== 1'b0 && n < 50);
    if (rsp.waitrequest !== 1'b0) begin err_total++; test_done(); end
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic wait_lvl(input logic hold, input logic lvl);
    int n;
    n = 0;
    while ((hold ? hold_req_o : cpu_driver_disable_o) !== lvl && n < 300) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 300) begin err_total++; test_done(); end
  endtask
  task automatic t_reset;
    @(negedge ref_clk_i);
    chk(8'(rsp.waitrequest), 8'h01);
    chk(8'(hold_req_o), 8'h00);
    chk(8'(chained_grant_o), 8'h00);
    acc(1'b0, 4'hf, `FBD_REG_CTRL, 8'h00);
    chk(q, `FBD_CTRL_RST);
    acc(1'b0, 4'hf, `FBD_REG_LINK, 8'h00);
    chk(q, `FBD_LINK_RST);
  endtask
  task automatic t_window;
    acc(1'b1, 4'hf, `FBD_REG_LINK, 8'h29);
    acc(1'b1, 4'he, `FBD_REG_LINK, 8'hff);
    acc(1'b0, 4'hf, `FBD_REG_LINK, 8'h00);
    chk(q, 8'h29);
    acc(1'b0, 4'he, `FBD_REG_LINK, 8'h00);
    chk(q, 8'h00);
  endtask
  task automatic t_xfer(input logic [7:0] link, input logic [2:0] ack, input logic [6:0] irq);
    acc(1'b1, 4'hf, `FBD_REG_LINK, link);
    acc(1'b1, 4'hf, `FBD_REG_CTRL, 8'h05);
    @(posedge ref_clk_i);
    floppy_req_i <= 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk(8'(hold_req_o), 8'h00);
    acc(1'b1, 4'hf, `FBD_REG_CMD, 8'h00);
    wait_lvl(1'b0, 1'b1);
    chk(8'(dma_channel_ack_o), 8'(ack));
    chk(8'(hold_req_o), 8'h01);
    wait_lvl(1'b1, 1'b0);
    @(posedge ref_clk_i);
    floppy_req_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(8'(cpu_driver_disable_o), 8'h00);
    chk(8'(drv.drive_sel), 8'h01);
    acc(1'b0, 4'hf, `FBD_REG_STAT, 8'h00);
    chk(q & 8'h01, 8'h01);
    chk(8'(interrupt_line_o), 8'(irq));
    acc(1'b1, 4'hf, `FBD_REG_STAT, 8'h01);
    acc(1'b1, 4'hf, `FBD_REG_CTRL, 8'h00);
    @(negedge ref_clk_i);
    chk(8'(interrupt_line_o), 8'h00);
  endtask
  task automatic t_lend;
    acc(1'b1, 4'hf, `FBD_REG_LINK, 8'h02);
    acc(1'b1, 4'hf, `FBD_REG_CTRL, 8'h00);
    @(posedge ref_clk_i);
    sub_req_i <= 1'b1;
    wait_lvl(1'b0, 1'b1);
    chk(8'(dma_channel_ack_o), 8'h02);
    @(negedge ref_clk_i);
    chk(8'(interrupt_line_o), 8'h20);
    @(posedge ref_clk_i);
    sub_req_i <= 1'b0;
    wait_lvl(1'b1, 1'b0);
    chk(8'(cpu_driver_disable_o), 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_window();
    t_xfer(8'h01, 3'b100, 7'h01);
    t_xfer(8'h12, 3'b100, 7'h04);
    t_xfer(8'h26, 3'b001, 7'h10);
    t_lend();
    test_done();
  end
endmodule
`default_nettype wire
